// ==== rtl/composite_output_port_interface.sv ====
// formats the four scaled sum chains onto four 18-bit output ports
`default_nettype none
// How it works
// R1: disabled port data lines held low
// R2: enabled port carries its chain sum
// R3: real select gives real, else complex
// R4: interleave puts I then Q on one port
// R5: I-flag high while I word is out
// R6: split mode chain0 ports 0/1, chain1 2/3
// R7: real rate half clock CDMA, full UMTS
// R8: split complex rate same limits as real
// R9: interleave rate half clock, word per cycle
// R10: drive bits 3 and 1 enable ports 3, 1
// R11: drive bit 2 enables port 2, test pins
// R12: drive bit 0 enables port 0, flag, clock
// R13: test clock period one plus rate value
// R14: test clock held high at rate 0, so no full-rate clock; sampleClk here pulses once per accepted sample
// R15: low bits below rounding forced to zero
// R16: all port lines change from registers together
module composite_output_port_interface
   import composite_port_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // sum chain results, one valid for all chains
   input wire logic sumValid,
   input wire logic [DATA_W-1:0] chain0I,
   input wire logic [DATA_W-1:0] chain0Q,
   input wire logic [DATA_W-1:0] chain1I,
   input wire logic [DATA_W-1:0] chain1Q,
   input wire logic [DATA_W-1:0] chain2I,
   input wire logic [DATA_W-1:0] chain2Q,
   input wire logic [DATA_W-1:0] chain3I,
   input wire logic [DATA_W-1:0] chain3Q,
   // configuration
   input wire logic [NUM_PORTS-1:0] portEnable,
   input wire logic realSelect,
   input wire logic interleaveSelect,
   input wire logic umtsMode,
   input wire logic [ROUND_W-1:0] roundSelect,
   input wire logic [NUM_PORTS-1:0] driveEnable,
   input wire logic [TEST_RATE_W-1:0] testRate,
   // data ports
   output logic [DATA_W-1:0] composite_port_0,
   output logic [DATA_W-1:0] composite_port_1,
   output logic [DATA_W-1:0] composite_port_2,
   output logic [DATA_W-1:0] composite_port_3,
   output logic [NUM_PORTS-1:0] portOe,
   // flag and sample clock
   output logic iFlag,
   output logic sampleClk,
   output logic flagClkOe,
   // test pins
   output logic testSync,
   output logic testFlag,
   output logic testClk,
   output logic testOe
);
   // ----------------------------------------------------------------
   // input arrays and rounding mask
   // ----------------------------------------------------------------
   word_type chainI [NUM_PORTS];
   word_type chainQ [NUM_PORTS];
   word_type roundMask;
   assign chainI[0] = chain0I;
   assign chainI[1] = chain1I;
   assign chainI[2] = chain2I;
   assign chainI[3] = chain3I;
   assign chainQ[0] = chain0Q;
   assign chainQ[1] = chain1Q;
   assign chainQ[2] = chain2Q;
   assign chainQ[3] = chain3Q;

   always_comb begin
      // R15: zero the bits below the rounding width
      unique case (roundSelect)
         ROUND_18: roundMask = MASK_18;
         ROUND_16: roundMask = MASK_16;
         ROUND_14: roundMask = MASK_14;
         ROUND_12: roundMask = MASK_12;
      endcase
   end

   // ----------------------------------------------------------------
   // sample acceptance and rate limit
   // ----------------------------------------------------------------
   logic complexInterl;
   logic halfRate;
   logic accept;
   logic lastAccept_q, lastAccept_d;
   phase_type phase_q, phase_d;
   logic iFlag_q, iFlag_d;
   logic sampleClk_q, sampleClk_d;
   logic testSync_q, testSync_d;

   assign complexInterl = !realSelect && interleaveSelect;
   // R7: CDMA real limited to half clock
   // R8: CDMA split complex limited likewise
   // R9: interleave always half clock
   assign halfRate = complexInterl || !umtsMode;
   // a valid right after an accepted one is dropped in half-rate modes
   assign accept = sumValid && !(halfRate && lastAccept_q);

   always_comb begin
      lastAccept_d = accept;
      // R4: Q follows the I word by one cycle
      if (accept && complexInterl) begin
         phase_d = PHASE_Q;
      end else begin
         phase_d = PHASE_I;
      end
      // R5: flag marks the I word only
      if (complexInterl) begin
         iFlag_d = accept;
      end else begin
         iFlag_d = 1'b0;
      end
      // R14: sample clock marks new samples; not a full-rate clock
      sampleClk_d = accept;
      testSync_d = accept;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lastAccept_q <= 1'b0;
         phase_q <= PHASE_I;
         iFlag_q <= 1'b0;
         sampleClk_q <= 1'b0;
         testSync_q <= 1'b0;
      end else begin
         lastAccept_q <= lastAccept_d;
         phase_q <= phase_d;
         iFlag_q <= iFlag_d;
         sampleClk_q <= sampleClk_d;
         testSync_q <= testSync_d;
      end
   end

   // ----------------------------------------------------------------
   // per-port data path
   // ----------------------------------------------------------------
   word_type portData_q [NUM_PORTS];
   word_type heldQ_q [NUM_PORTS];

   genvar k;
   generate
      for (k = 0; k < NUM_PORTS; k++) begin : g_port
         word_type portData_d;
         word_type heldQ_d;
         word_type splitWord;

         always_comb begin
            // R6: split complex wiring
            unique case (k)
               SPLIT_I_PORT_A: splitWord = chainI[SPLIT_CHAIN_A];
               SPLIT_Q_PORT_A: splitWord = chainQ[SPLIT_CHAIN_A];
               SPLIT_I_PORT_B: splitWord = chainI[SPLIT_CHAIN_B];
               SPLIT_Q_PORT_B: splitWord = chainQ[SPLIT_CHAIN_B];
               default: splitWord = DATA_RESET;
            endcase
            heldQ_d = heldQ_q[k];
            portData_d = portData_q[k];
            if (!portEnable[k]) begin
               // R1: disabled port held low
               portData_d = DATA_RESET;
            end else if (accept) begin
               // R3: real or complex selection
               if (realSelect) begin
                  // R2: own chain sum on the port
                  portData_d = chainI[k] & roundMask;
               end else if (interleaveSelect) begin
                  // R9: I now, Q on the next cycle
                  portData_d = chainI[k] & roundMask;
                  heldQ_d = chainQ[k] & roundMask;
               end else begin
                  portData_d = splitWord & roundMask;
               end
            end else if (phase_q == PHASE_Q) begin
               portData_d = heldQ_q[k];
            end
         end

         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               portData_q[k] <= DATA_RESET;
               heldQ_q[k] <= DATA_RESET;
            end else begin
               portData_q[k] <= portData_d;
               heldQ_q[k] <= heldQ_d;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // output drive enables
   // ----------------------------------------------------------------
   logic [NUM_PORTS-1:0] portOe_q, portOe_d;
   logic flagClkOe_q, flagClkOe_d;
   logic testOe_q, testOe_d;

   always_comb begin
      // R10: one drive bit per data port
      portOe_d = driveEnable;
      // R12: bit 0 also drives flag and sample clock
      flagClkOe_d = driveEnable[0];
      // R11: bit 2 also drives the test pins
      testOe_d = driveEnable[2];
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         portOe_q <= 4'h0;
         flagClkOe_q <= 1'b0;
         testOe_q <= 1'b0;
      end else begin
         portOe_q <= portOe_d;
         flagClkOe_q <= flagClkOe_d;
         testOe_q <= testOe_d;
      end
   end

   // ----------------------------------------------------------------
   // test clock
   // ----------------------------------------------------------------
   // R13: divided test clock
   test_clock_divider u_test_clock (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .testRate (testRate),
      .testClk (testClk)
   );

   // R16: every port line comes straight from a flop
   assign composite_port_0 = portData_q[0];
   assign composite_port_1 = portData_q[1];
   assign composite_port_2 = portData_q[2];
   assign composite_port_3 = portData_q[3];
   assign portOe = portOe_q;
   assign iFlag = iFlag_q;
   assign sampleClk = sampleClk_q;
   assign flagClkOe = flagClkOe_q;
   assign testSync = testSync_q;
   assign testFlag = iFlag_q;
   assign testOe = testOe_q;
endmodule : composite_output_port_interface
`default_nettype wire

// ==== rtl/composite_port_pkg.sv ====
// shared constants and types for the composite output port block
`default_nettype none
package composite_port_pkg;
   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int DATA_W = 18;
   localparam int NUM_PORTS = 4;
   localparam int TEST_RATE_W = 8;
   localparam int ROUND_W = 2;
   // ----------------------------------------------------------------
   // rounding codes and low bits zeroed for each
   // ----------------------------------------------------------------
   localparam logic [ROUND_W-1:0] ROUND_18 = 2'h0;
   localparam logic [ROUND_W-1:0] ROUND_16 = 2'h1;
   localparam logic [ROUND_W-1:0] ROUND_14 = 2'h2;
   localparam logic [ROUND_W-1:0] ROUND_12 = 2'h3;
   localparam logic [DATA_W-1:0] MASK_18 = 18'h3ffff;
   localparam logic [DATA_W-1:0] MASK_16 = 18'h3fffc;
   localparam logic [DATA_W-1:0] MASK_14 = 18'h3fff0;
   localparam logic [DATA_W-1:0] MASK_12 = 18'h3ffc0;
   // ----------------------------------------------------------------
   // port wiring for split complex output
   // ----------------------------------------------------------------
   localparam int SPLIT_I_PORT_A = 0;
   localparam int SPLIT_Q_PORT_A = 1;
   localparam int SPLIT_I_PORT_B = 2;
   localparam int SPLIT_Q_PORT_B = 3;
   localparam int SPLIT_CHAIN_A = 0;
   localparam int SPLIT_CHAIN_B = 1;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
   localparam logic [TEST_RATE_W-1:0] COUNT_RESET = 8'h00;
   // ----------------------------------------------------------------
   // interleave phase: which word goes out next
   // ----------------------------------------------------------------
   typedef enum logic {
      PHASE_I = 1'b0,
      PHASE_Q = 1'b1
   } phase_type;
   typedef logic [DATA_W-1:0] word_type;
endpackage : composite_port_pkg
`default_nettype wire

// ==== rtl/test_clock_divider.sv ====
// divided test clock: period of one plus the programmed rate
`default_nettype none
module test_clock_divider
   import composite_port_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // rate control
   input wire logic [TEST_RATE_W-1:0] testRate,
   // divided clock
   output logic testClk
);
   // ----------------------------------------------------------------
   // period counter
   // ----------------------------------------------------------------
   logic [TEST_RATE_W-1:0] count_q, count_d;
   logic [TEST_RATE_W:0] highLen;
   logic testClk_q, testClk_d;

   always_comb begin
      // high for the first half, rounded up
      highLen = ({1'b0, testRate} + 9'h002) >> 1;
      // R13: wrap at rate
      if (count_q >= testRate) begin
         count_d = COUNT_RESET;
      end else begin
         count_d = count_q + 8'h01;
      end
      testClk_d = ({1'b0, count_d} < highLen);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_q <= COUNT_RESET;
         testClk_q <= 1'b0;
      end else begin
         count_q <= count_d;
         testClk_q <= testClk_d;
      end
   end

   assign testClk = testClk_q;
endmodule : test_clock_divider
`default_nettype wire

// ==== tb/composite_port_properties.sv ====
// checker for the composite output port block
`default_nettype none
module composite_port_properties
   import composite_port_pkg::*;
(
   // clock, reset, controls
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sumValid,
   input wire logic [NUM_PORTS-1:0] portEnable,
   input wire logic realSelect,
   input wire logic interleaveSelect,
   input wire logic umtsMode,
   input wire logic [NUM_PORTS-1:0] driveEnable,
   input wire logic [TEST_RATE_W-1:0] testRate,
   // watched outputs
   input wire logic [DATA_W-1:0] composite_port_0,
   input wire logic [NUM_PORTS-1:0] portOe,
   input wire logic iFlag,
   input wire logic sampleClk,
   input wire logic flagClkOe,
   input wire logic testSync,
   input wire logic testFlag,
   input wire logic testClk,
   input wire logic testOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   port_low_a: assert property (
      !portEnable[0] |=> composite_port_0 == '0) else $error("port 0 live");
   iflag_mode_a: assert property (
      iFlag |-> $past(!realSelect && interleaveSelect))
      else $error("stray flag");
   iflag_pair_a: assert property (
      iFlag |-> sampleClk ##1 !iFlag && !sampleClk) else $error("bad I/Q pair");
   full_rate_a: assert property (
      sumValid && umtsMode && realSelect |=> sampleClk) else $error("dropped");
   half_rate_a: assert property (
      sampleClk && !umtsMode |=> !sampleClk) else $error("rate too high");
   port_oe_a: assert property (
      1'b1 |=> portOe == $past(driveEnable)) else $error("port oe wrong");
   pin_oe_a: assert property (
      $changed(driveEnable) |=> {testOe, flagClkOe} ==
         {$past(driveEnable[2]), $past(driveEnable[0])}) else $error("pin oe");
   full_clk_a: assert property (
      testRate == 8'h00 |=> testClk) else $error("test clock not high");
   test_copy_a: assert property (
      testSync == sampleClk && testFlag == iFlag) else $error("test pins");
endmodule : composite_port_properties
bind composite_output_port_interface composite_port_properties u_props (.*);
`default_nettype wire

// ==== tb/dac_sink_model.sv ====
// converter-side capture of the words on ports 0 and 1
`default_nettype none
module dac_sink_model
   import composite_port_pkg::*;
(
   // clock and converter pins
   input wire logic sys_clk,
   input wire logic sampleClk,
   input wire logic iFlag,
   input wire logic interleaved,
   input wire word_type dataI,
   input wire word_type dataQ,
   // captured words
   output var word_type gotI,
   output var word_type gotQ
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // capture, Q trails the flagged I word by one cycle
   // ----------------------------------------------------------------
   logic wasI = 1'b0;
   always @(posedge sys_clk) begin
      wasI <= iFlag;
      if (sampleClk) begin
         gotI <= dataI;
      end
      if (interleaved ? wasI : sampleClk) begin
         gotQ <= interleaved ? dataI : dataQ;
      end
   end
endmodule : dac_sink_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the composite output port block
`default_nettype none
module tb
   import composite_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // stimulus, expectations, checks
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0, sys_rst = 1'b1, sumValid = 1'b0, prev;
   logic realSelect = 1'b1, interleaveSelect = 1'b0, umtsMode = 1'b1;
   logic [ROUND_W-1:0] roundSelect = 2'h0;
   logic [NUM_PORTS-1:0] portEnable = 4'hf, driveEnable = 4'h0, portOe;
   logic [TEST_RATE_W-1:0] testRate = 8'h00;
   word_type ci [4] = '{default: '0}, cq [4] = '{default: '0};
   word_type ei [4], eq [4], w [4], wi, gotI, gotQ;
   wire word_type port [4];
   logic iFlag, sampleClk, flagClkOe, testSync, testFlag, testClk, testOe;
   int err_count = 0, checked = 0, rises;
   always #2.5 sys_clk = ~sys_clk;
   composite_output_port_interface u_dut (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .sumValid(sumValid), .chain0I(ci[0]), .chain0Q(cq[0]),
      .chain1I(ci[1]), .chain1Q(cq[1]), .chain2I(ci[2]), .chain2Q(cq[2]),
      .chain3I(ci[3]), .chain3Q(cq[3]), .portEnable(portEnable),
      .realSelect(realSelect), .interleaveSelect(interleaveSelect),
      .umtsMode(umtsMode), .roundSelect(roundSelect), .testRate(testRate),
      .driveEnable(driveEnable), .composite_port_0(port[0]),
      .composite_port_1(port[1]), .composite_port_2(port[2]),
      .composite_port_3(port[3]), .portOe(portOe), .iFlag(iFlag),
      .sampleClk(sampleClk), .flagClkOe(flagClkOe), .testSync(testSync),
      .testFlag(testFlag), .testClk(testClk), .testOe(testOe));
   dac_sink_model u_dac (.sys_clk(sys_clk), .sampleClk(sampleClk),
      .iFlag(iFlag), .interleaved(interleaveSelect), .dataI(port[0]),
      .dataQ(port[1]), .gotI(gotI), .gotQ(gotQ));
   // low bits below the kept width read as zero
   function automatic word_type m(input word_type x);
      return x & ~((18'h1 << (2 * roundSelect)) - 18'h1);
   endfunction : m
   task automatic chk(input word_type got, input word_type exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // hold keeps sumValid up so the next call is back to back
   task automatic give(input bit hold);
      for (int k = 0; k < 4; k++) begin
         ci[k] = 18'($urandom);
         cq[k] = 18'($urandom);
      end
      sumValid = 1'b1;
      ei = ci;
      eq = cq;
      @(posedge sys_clk);
      #1;
      if (!hold) sumValid = 1'b0;
   endtask : give
   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      #20000;
      err_count++;
      $display("mismatch %0t watchdog expired", $time);
      test_done;
   end
   initial begin
      void'($urandom(32'heb77));
      repeat (3) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      for (int n = 0; n < 6; n++) begin
         roundSelect = 2'($urandom);
         give(n < 5);
         for (int k = 0; k < 4; k++) chk(port[k], m(ei[k]));
      end
      $display("test real done");
      realSelect = 1'b0;
      for (int n = 0; n < 4; n++) begin
         give(n < 3);
         chk(port[0], m(ei[0]));
         chk(port[1], m(eq[0]));
         chk(port[2], m(ei[1]));
         chk(port[3], m(eq[1]));
      end
      @(posedge sys_clk);
      #1;
      chk(gotI, m(ei[0]));
      chk(gotQ, m(eq[0]));
      $display("test split done");
      interleaveSelect = 1'b1;
      umtsMode = 1'b0;
      @(posedge sys_clk);
      #1;
      give(1);
      w = eq;
      wi = ei[0];
      for (int k = 0; k < 4; k++) chk(port[k], m(ei[k]));
      chk(18'(iFlag), 18'h1);
      give(0);
      for (int k = 0; k < 4; k++) chk(port[k], m(w[k]));
      chk(18'(iFlag), 18'h0);
      @(posedge sys_clk);
      #1;
      for (int k = 0; k < 4; k++) chk(port[k], m(w[k]));
      chk(gotQ, m(w[0]));
      chk(gotI, m(wi));
      $display("test interleave done");
      for (int n = 0; n < 5; n++) begin
         repeat (2) @(posedge sys_clk);
         #1;
         portEnable = 4'($urandom);
         driveEnable = 4'($urandom);
         give(0);
         for (int k = 0; k < 4; k++)
            chk(port[k], portEnable[k] ? m(ei[k]) : '0);
         chk(18'(portOe), 18'(driveEnable));
         chk(18'({testOe, flagClkOe}),
            18'({driveEnable[2], driveEnable[0]}));
      end
      $display("test enables done");
      // cdma real: a valid right after an accepted one is dropped
      realSelect = 1'b1;
      interleaveSelect = 1'b0;
      portEnable = 4'hf;
      @(posedge sys_clk);
      #1;
      give(1);
      for (int k = 0; k < 4; k++) chk(port[k], m(ei[k]));
      w = ei;
      give(0);
      for (int k = 0; k < 4; k++) chk(port[k], m(w[k]));
      $display("test cdma real done");
      testRate = 8'($urandom_range(7, 1));
      repeat (12) @(posedge sys_clk);
      #1;
      rises = 0;
      prev = testClk;
      repeat (8 * (testRate + 1)) begin
         @(posedge sys_clk);
         #1;
         rises += int'(testClk && !prev);
         prev = testClk;
      end
      chk(18'(rises), 18'h8);
      $display("test clock done");
      test_done;
   end
endmodule : tb
`default_nettype wire
